// ### design/dswc_top.sv
// deep sleep wake control: wake capture, exit reset, sleep watchdog, axi4-lite registers
//
// Behaviour
// - leave deep sleep on clear, power-on, alarm, pin0, watchdog or ulp wake.
// - every exit runs the power-on reset sequence, then fetches the reset vector.
// - exit from deep sleep sets the exit flag, bit 3 of watchdog control.
// - only a firmware write clears the exit flag; hardware never does.
// - both wake status registers clear automatically on each deep sleep entry.
// - wake events are logged only while fully in deep sleep.
// - source during entry: interrupt vector if fully enabled, else abort entry.
// - only the first asserting source is logged; later ones are not.
// - watchdog postscaler from a 4-bit period field, about 2.1 ms to 25.7 days.
// - a clock select bit picks internal rc or timer1 as watchdog clock.
// - watchdog counts only when its enable bit is set.
// - watchdog count clears to zero on every deep sleep entry.
// - pins hold sleep states after wake until firmware clears the release bit.
// - master clear wake releases pins automatically; retention registers keep contents.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "dswc_defs.svh"

module dswc_top
   import dswc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // axi4-lite write channels
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // core side
   input wire logic sleep_request,
   input wire logic [5:0] irq_full_en,
   output logic deep_sleep_active,
   output logic por_hold,
   output logic fetch_reset_vector,
   output logic take_irq_vector,
   output logic entry_abort,
   output logic pins_hold,
   // wake sources, levels
   input wire logic master_clear_pin,
   input wire logic power_on_event,
   input wire logic calendar_alarm,
   input wire logic external_irq_pin0,
   input wire logic ultra_low_power_wake,
   // watchdog clock ticks, one-cycle enables
   input wire logic internal_rc_osc,
   input wire logic timer1_crystal_osc
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   dswc_state_t state;
   logic [5:0] timer;
   logic [10:0] ctrl;
   logic deep_sleep_exit_flag;
   dswc_src_t wake_log;
   logic [31:0] retention_reg_0;
   logic [31:0] retention_reg_1;
   dswc_wdt_count_t wdt_count;
   dswc_wdt_count_t wdt_limit;
   logic wdt_fire;
   logic wdt_tick;
   logic [5:0] wdt_shift;
   dswc_src_t src_live;
   dswc_src_t src_first;
   logic aw_ok;
   logic w_ok;
   logic ar_ok;
   logic [7:0] aw_addr;
   logic [7:0] ar_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic wr_hit;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic entry_done;
   logic log_event;
   logic [31:0] wr_mask;
   logic [7:0] wake_source_status_low;
   logic [7:0] wake_source_status_high;

   ////////////////////////////////////////////////////////////////////////////
   // wake sources and priority pick
   assign src_live[`DSWC_SRC_MASTER_CLEAR_PIN] = master_clear_pin;
   assign src_live[`DSWC_SRC_POR] = power_on_event;
   assign src_live[`DSWC_SRC_WDT] = wdt_fire;
   assign src_live[`DSWC_SRC_CAL] = calendar_alarm & ctrl[`DSWC_CTRL_CAL_EN];
   assign src_live[`DSWC_SRC_EXTERNAL_IRQ_PIN0] = external_irq_pin0 & ctrl[`DSWC_CTRL_EXTERNAL_IRQ_PIN0_EN];
   assign src_live[`DSWC_SRC_ULP] = ultra_low_power_wake & ctrl[`DSWC_CTRL_ULP_EN];
   assign src_first = src_live & (~src_live + 6'h01);
   assign entry_done = (state == DSWC_ENTER) && (src_live == 6'h00) && (timer == 6'h00);
   // capture only in full deep sleep
   assign log_event = (state == DSWC_SLEEP) && (src_live != 6'h00);

   ////////////////////////////////////////////////////////////////////////////
   // power state sequencer
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= DSWC_RUN;
         timer <= 6'h00;
      end else begin
         unique case (state)
            DSWC_RUN: begin
               if (sleep_request) begin
                  state <= DSWC_ENTER;
                  timer <= 6'(`DSWC_ENTRY_CYCLES - 1);
               end
            end
            DSWC_ENTER: begin
               if (src_live != 6'h00) begin
                  state <= DSWC_RUN;
               end else if (timer == 6'h00) begin
                  state <= DSWC_SLEEP;
               end else begin
                  timer <= timer - 6'h01;
               end
            end
            DSWC_SLEEP: begin
               if (log_event) begin
                  state <= DSWC_POR;
                  timer <= 6'(`DSWC_POR_CYCLES - 1);
               end
            end
            DSWC_POR: begin
               if (timer == 6'h00) begin
                  state <= DSWC_RUN;
               end else begin
                  timer <= timer - 6'h01;
               end
            end
         endcase
      end
   end

   // core side outputs, all registered
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         deep_sleep_active <= 1'b0;
         por_hold <= 1'b0;
         fetch_reset_vector <= 1'b0;
         take_irq_vector <= 1'b0;
         entry_abort <= 1'b0;
      end else begin
         deep_sleep_active <= entry_done || (state == DSWC_SLEEP && !log_event);
         por_hold <= log_event || (state == DSWC_POR && timer != 6'h00);
         fetch_reset_vector <= (state == DSWC_POR) && (timer == 6'h00);
         take_irq_vector <= (state == DSWC_ENTER) && ((src_first & irq_full_en) != 6'h00);
         entry_abort <= (state == DSWC_ENTER) && (src_live != 6'h00)
            && ((src_first & irq_full_en) == 6'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake source log
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wake_log <= 6'h00;
      end else if (entry_done) begin
         wake_log <= 6'h00;
      end else if (log_event && wake_log == 6'h00) begin
         wake_log <= src_first;
      end
   end

   // flag set on exit; cleared only by firmware, set wins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         deep_sleep_exit_flag <= 1'b0;
      end else if (log_event) begin
         deep_sleep_exit_flag <= 1'b1;
      end else if (wr_go && aw_addr == `DSWC_ADDR_WATCHDOG_CONTROL_REG && w_strb[0]
                   && !w_data[`DSWC_EXIT_FLAG_BIT]) begin
         deep_sleep_exit_flag <= 1'b0;
      end
   end

   // pins held from entry until release cleared or a master clear wake
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pins_hold <= 1'b0;
      end else if (entry_done) begin
         pins_hold <= 1'b1;
      end else if (log_event && src_first[`DSWC_SRC_MASTER_CLEAR_PIN]) begin
         pins_hold <= 1'b0;
      end else if (wr_go && aw_addr == `DSWC_ADDR_PINCTL && w_strb[0]
                   && !w_data[`DSWC_RELEASE_BIT]) begin
         pins_hold <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep watchdog
   // clock source choice
   assign wdt_tick = ctrl[`DSWC_CTRL_CLK_SEL] ? timer1_crystal_osc : internal_rc_osc;
   assign wdt_shift = `DSWC_WDT_BASE_SHIFT
      + 6'(ctrl[`DSWC_CTRL_PS_LSB +: 4] * `DSWC_WDT_STEP_SHIFT);
   assign wdt_limit = (36'h1 << wdt_shift) - 36'h1;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wdt_count <= 36'h0;
         wdt_fire <= 1'b0;
      end else if (state != DSWC_SLEEP) begin
         wdt_count <= 36'h0;
         wdt_fire <= 1'b0;
      end else if (ctrl[`DSWC_CTRL_WDT_EN] && wdt_tick && !wdt_fire) begin
         wdt_count <= wdt_count + 36'h1;
         wdt_fire <= (wdt_count == wdt_limit);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path
   assign wr_go = aw_ok && w_ok && !s_bvalid;
   assign wr_hit = (aw_addr == `DSWC_ADDR_CTRL) || (aw_addr == `DSWC_ADDR_WATCHDOG_CONTROL_REG)
      || (aw_addr == `DSWC_ADDR_RETAIN0) || (aw_addr == `DSWC_ADDR_RETAIN1)
      || (aw_addr == `DSWC_ADDR_PINCTL);
   assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   // address and data capture, either order
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aw_ok <= 1'b0;
         w_ok <= 1'b0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_ok <= 1'b1;
            aw_addr <= s_awaddr;
            s_awready <= 1'b0;
         end else if (wr_go) begin
            aw_ok <= 1'b0;
         end else if (!aw_ok) begin
            s_awready <= 1'b1;
         end
         if (s_wvalid && s_wready) begin
            w_ok <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
            s_wready <= 1'b0;
         end else if (wr_go) begin
            w_ok <= 1'b0;
         end else if (!w_ok) begin
            s_wready <= 1'b1;
         end
      end
   end

   // write response
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_bvalid <= 1'b0;
         s_bresp <= `DSWC_RESP_OKAY;
      end else if (wr_go) begin
         s_bvalid <= 1'b1;
         s_bresp <= wr_hit ? `DSWC_RESP_OKAY : `DSWC_RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // control and retention registers; retention survives wake
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= `DSWC_CTRL_RESET;
         retention_reg_0 <= 32'h0;
         retention_reg_1 <= 32'h0;
      end else if (wr_go) begin
         if (aw_addr == `DSWC_ADDR_CTRL) begin
            ctrl <= (ctrl & ~wr_mask[10:0]) | (w_data[10:0] & wr_mask[10:0]);
         end
         if (aw_addr == `DSWC_ADDR_RETAIN0) begin
            retention_reg_0 <= (retention_reg_0 & ~wr_mask) | (w_data & wr_mask);
         end
         if (aw_addr == `DSWC_ADDR_RETAIN1) begin
            retention_reg_1 <= (retention_reg_1 & ~wr_mask) | (w_data & wr_mask);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path
   always_comb begin
      wake_source_status_low = 8'h00;
      wake_source_status_high = 8'h00;
      wake_source_status_low[`DSWC_LOW_POR] = wake_log[`DSWC_SRC_POR];
      wake_source_status_low[`DSWC_LOW_MASTER_CLEAR_PIN] = wake_log[`DSWC_SRC_MASTER_CLEAR_PIN];
      wake_source_status_low[`DSWC_LOW_CAL] = wake_log[`DSWC_SRC_CAL];
      wake_source_status_low[`DSWC_LOW_WDT] = wake_log[`DSWC_SRC_WDT];
      wake_source_status_low[`DSWC_LOW_ULP] = wake_log[`DSWC_SRC_ULP];
      wake_source_status_high[`DSWC_HIGH_EXTERNAL_IRQ_PIN0] = wake_log[`DSWC_SRC_EXTERNAL_IRQ_PIN0];
      rd_hit = 1'b1;
      rd_mux = 32'h0;
      unique case (ar_addr)
         `DSWC_ADDR_CTRL: rd_mux = {21'h0, ctrl};
         `DSWC_ADDR_WATCHDOG_CONTROL_REG: rd_mux = {28'h0, deep_sleep_exit_flag, 3'h0};
         `DSWC_ADDR_WAKE_LOW: rd_mux = {24'h0, wake_source_status_low};
         `DSWC_ADDR_WAKE_HIGH: rd_mux = {24'h0, wake_source_status_high};
         `DSWC_ADDR_RETAIN0: rd_mux = retention_reg_0;
         `DSWC_ADDR_RETAIN1: rd_mux = retention_reg_1;
         `DSWC_ADDR_PINCTL: rd_mux = {31'h0, pins_hold};
         `DSWC_ADDR_STATE: rd_mux = {30'h0, state};
         default: rd_hit = 1'b0;
      endcase
   end

   // address capture and data return
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ar_ok <= 1'b0;
         ar_addr <= 8'h00;
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= `DSWC_RESP_OKAY;
      end else begin
         if (s_arvalid && s_arready) begin
            ar_ok <= 1'b1;
            ar_addr <= s_araddr;
            s_arready <= 1'b0;
         end else if (ar_ok && !s_rvalid) begin
            ar_ok <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_mux;
            s_rresp <= rd_hit ? `DSWC_RESP_OKAY : `DSWC_RESP_SLVERR;
         end else if (!ar_ok && !s_rvalid) begin
            s_arready <= 1'b1;
         end
         if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ### pkg/dswc_defs.svh
// register offsets, field positions, reset values and timing counts of the deep sleep wake block
`ifndef DSWC_DEFS_SVH
`define DSWC_DEFS_SVH
// byte addresses
`define DSWC_ADDR_CTRL 8'h00
`define DSWC_ADDR_WATCHDOG_CONTROL_REG 8'h04
`define DSWC_ADDR_WAKE_LOW 8'h08
`define DSWC_ADDR_WAKE_HIGH 8'h0c
`define DSWC_ADDR_RETAIN0 8'h10
`define DSWC_ADDR_RETAIN1 8'h14
`define DSWC_ADDR_PINCTL 8'h18
`define DSWC_ADDR_STATE 8'h1c
// control register fields
`define DSWC_CTRL_WDT_EN 2
`define DSWC_CTRL_CLK_SEL 3
`define DSWC_CTRL_PS_LSB 4
`define DSWC_CTRL_CAL_EN 8
`define DSWC_CTRL_EXTERNAL_IRQ_PIN0_EN 9
`define DSWC_CTRL_ULP_EN 10
`define DSWC_CTRL_RESET 11'h000
// watchdog control register: exit flag position
`define DSWC_EXIT_FLAG_BIT 3
// pin control: release bit position
`define DSWC_RELEASE_BIT 0
// wake source index, also capture priority (lowest index wins)
`define DSWC_SRC_MASTER_CLEAR_PIN 0
`define DSWC_SRC_POR 1
`define DSWC_SRC_WDT 2
`define DSWC_SRC_CAL 3
`define DSWC_SRC_EXTERNAL_IRQ_PIN0 4
`define DSWC_SRC_ULP 5
// status low bit positions of each logged source; external_irq_pin0 sits in status high bit 0
`define DSWC_LOW_POR 0
`define DSWC_LOW_MASTER_CLEAR_PIN 2
`define DSWC_LOW_CAL 3
`define DSWC_LOW_WDT 4
`define DSWC_LOW_ULP 5
`define DSWC_HIGH_EXTERNAL_IRQ_PIN0 0
// sleep watchdog: timeout = 2^(base + step*period) source ticks, 2.1 ms .. 25.7 days
`define DSWC_WDT_BASE_SHIFT 6'd6
`define DSWC_WDT_STEP_SHIFT 2
// timing: entry completion and power-on reset sequence
`define DSWC_CLK_MHZ 40
`define DSWC_ENTRY_TIME_NS 200
`define DSWC_POR_TIME_NS 1000
`define DSWC_ENTRY_CYCLES ((`DSWC_ENTRY_TIME_NS * `DSWC_CLK_MHZ + 999) / 1000)
`define DSWC_POR_CYCLES ((`DSWC_POR_TIME_NS * `DSWC_CLK_MHZ + 999) / 1000)
// bus responses
`define DSWC_RESP_OKAY 2'b00
`define DSWC_RESP_SLVERR 2'b10
`endif

// ### pkg/dswc_pkg.sv
// types of the deep sleep wake block
package dswc_pkg;
   typedef enum logic [1:0] {DSWC_RUN, DSWC_ENTER, DSWC_SLEEP, DSWC_POR} dswc_state_t;
   typedef logic [5:0] dswc_src_t;
   typedef logic [35:0] dswc_wdt_count_t;
endpackage

// ### verification/dswc_asserts.sv
// port checker of the deep sleep wake block
`timescale 1ns/1ps
module dswc_asserts
   import dswc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // core side
   input wire logic sleep_request,
   input wire logic deep_sleep_active,
   input wire logic por_hold,
   input wire logic fetch_reset_vector,
   input wire logic take_irq_vector,
   input wire logic entry_abort,
   input wire logic pins_hold,
   // always enabled wake sources
   input wire logic master_clear_pin,
   input wire logic power_on_event
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [7:0] por_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // length of the running reset sequence
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         por_cnt <= 8'h00;
      end else if (por_hold) begin
         por_cnt <= por_cnt + 8'h01;
      end else begin
         por_cnt <= 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_entry_nine_edges: assert property (
      $rose(deep_sleep_active) |-> $past(sleep_request, 9)) else $error("entry time wrong");
   a_wake_starts_por: assert property (
      deep_sleep_active && (master_clear_pin || power_on_event) |=> por_hold && !deep_sleep_active)
      else $error("wake did not start reset");
   a_por_length: assert property (
      $fell(por_hold) |-> por_cnt inside {[8'd39:8'd41]}) else $error("reset length wrong");
   a_fetch_after_por: assert property (
      fetch_reset_vector |-> !por_hold && ($past(por_hold) || $past(por_hold, 2)))
      else $error("fetch without reset");
   a_fetch_one_cycle: assert property (
      fetch_reset_vector |=> !fetch_reset_vector) else $error("fetch pulse too long");
   a_abort_one_way: assert property (
      take_irq_vector || entry_abort |-> !(take_irq_vector && entry_abort) && !deep_sleep_active
      && !por_hold) else $error("abort outputs wrong");
   a_pins_in_sleep: assert property (
      deep_sleep_active |-> pins_hold) else $error("pins free in sleep");
   a_por_pins_kept: assert property (
      deep_sleep_active && !master_clear_pin && power_on_event |=> pins_hold[*8])
      else $error("pins released early");
   a_clear_releases: assert property (
      deep_sleep_active && master_clear_pin |-> ##[1:45] !pins_hold) else $error("pins kept");
   c_asleep: cover property ($rose(deep_sleep_active));
   c_irq: cover property (take_irq_vector);
   c_abort: cover property (entry_abort);
endmodule
bind dswc_top dswc_asserts dswc_asserts_i (.*);

// ### verification/dswc_bench.sv
// testbench of the deep sleep wake block
`timescale 1ns/1ps
`include "dswc_defs.svh"
module dswc_bench;
   logic mclk = 1'b0, resetn = 1'b0, sleep_request = 1'b0, t1_on = 1'b0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata;
   logic [3:0] s_wstrb = 4'h0;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic [5:0] irq_full_en = 6'h00;
   logic [4:0] fire = 5'h00;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, deep_sleep_active, por_hold;
   logic fetch_reset_vector, take_irq_vector, entry_abort, pins_hold;
   logic [1:0] s_bresp, s_rresp;
   logic master_clear_pin, power_on_event, calendar_alarm, external_irq_pin0;
   logic ultra_low_power_wake, internal_rc_osc, timer1_crystal_osc;
   int errors = 0, n_tests = 0, n;
   dswc_top dswc_top_i (.*);
   dswc_wake_model dswc_wake_model_i (.*);
   always #12.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [1:0] resp(input logic [7:0] a);
      return (a > `DSWC_ADDR_STATE) ? `DSWC_RESP_SLVERR : `DSWC_RESP_OKAY;
   endfunction
   // bus write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
      int t;
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= st;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge mclk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) break;
      end
      s_bready <= 1'b0;
      chk(32'({s_bvalid, s_bresp}), 32'({1'b1, resp(a)}), "bresp");
      @(posedge mclk);
   endtask
   // bus read with expected word
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      int t;
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge mclk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) break;
      end
      s_rready <= 1'b0;
      chk(s_rdata, exp, what);
      chk(32'({s_rvalid, s_rresp}), 32'({1'b1, resp(a)}), "rresp");
      @(posedge mclk);
   endtask
   // sleep request, wait until fully asleep
   task automatic go_sleep();
      int t;
      sleep_request <= 1'b1;
      @(posedge mclk);
      sleep_request <= 1'b0;
      for (t = 0; t < 20 && deep_sleep_active !== 1'b1; t++) @(posedge mclk);
      chk(32'(deep_sleep_active), 32'h1, "asleep");
   endtask
   // raise sources, wait for the reset vector fetch
   task automatic wake(input logic [4:0] src, output int t);
      fire <= src;
      for (t = 0; t < 400 && fetch_reset_vector !== 1'b1; t++) @(posedge mclk);
      fire <= 5'h00;
      chk(32'(fetch_reset_vector), 32'h1, "fetch");
      @(posedge mclk);
   endtask
   // pin0 during entry
   task automatic try_abort(input logic [5:0] ien, input logic want_irq);
      int t;
      irq_full_en <= ien;
      fire <= 5'h08;
      sleep_request <= 1'b1;
      @(posedge mclk);
      sleep_request <= 1'b0;
      for (t = 0; t < 20 && !take_irq_vector && !entry_abort; t++) @(posedge mclk);
      chk(32'({take_irq_vector, entry_abort}), 32'({want_irq, !want_irq}), "abort");
      fire <= 5'h00;
      repeat (3) @(posedge mclk);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // whole run watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      stop_test();
   end
   // main sequence
   initial begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rd(`DSWC_ADDR_CTRL, 32'h0, "ctrl");
      rd(`DSWC_ADDR_WATCHDOG_CONTROL_REG, 32'h0, "flag");
      rd(`DSWC_ADDR_WAKE_LOW, 32'h0, "low");
      rd(8'h20, 32'h0, "unmapped");
      wr(8'h24, 32'h1, 4'hf);
      wr(`DSWC_ADDR_RETAIN0, 32'hcafe1234, 4'hf);
      wr(`DSWC_ADDR_RETAIN0, 32'h0, 4'h1);
      wr(`DSWC_ADDR_CTRL, 32'h300, 4'hf);
      go_sleep();
      wake(5'h04, n);
      rd(`DSWC_ADDR_WAKE_LOW, 32'h08, "low");
      rd(`DSWC_ADDR_WATCHDOG_CONTROL_REG, 32'h08, "flag");
      rd(`DSWC_ADDR_PINCTL, 32'h1, "pins");
      rd(`DSWC_ADDR_STATE, 32'h0, "state");
      go_sleep();
      rd(`DSWC_ADDR_WAKE_LOW, 32'h0, "low");
      wake(5'h08, n);
      rd(`DSWC_ADDR_WAKE_HIGH, 32'h1, "high");
      // same cycle, then a later source
      wr(`DSWC_ADDR_CTRL, 32'h500, 4'hf);
      go_sleep();
      wake(5'h14, n);
      rd(`DSWC_ADDR_WAKE_LOW, 32'h08, "low");
      go_sleep();
      fire <= 5'h10;
      repeat (3) @(posedge mclk);
      wake(5'h14, n);
      rd(`DSWC_ADDR_WAKE_LOW, 32'h20, "low");
      // flag and pins need firmware writes
      wr(`DSWC_ADDR_WATCHDOG_CONTROL_REG, 32'h0, 4'h2);
      rd(`DSWC_ADDR_WATCHDOG_CONTROL_REG, 32'h08, "flag");
      wr(`DSWC_ADDR_WATCHDOG_CONTROL_REG, 32'h0, 4'h1);
      rd(`DSWC_ADDR_WATCHDOG_CONTROL_REG, 32'h0, "flag");
      wr(`DSWC_ADDR_PINCTL, 32'h0, 4'h1);
      rd(`DSWC_ADDR_PINCTL, 32'h0, "pins");
      wr(`DSWC_ADDR_CTRL, 32'h200, 4'hf);
      try_abort(6'h10, 1'b1);
      try_abort(6'h00, 1'b0);
      go_sleep();
      wake(5'h02, n);
      rd(`DSWC_ADDR_WAKE_LOW, 32'h01, "low");
      // partial count, then full count after entry
      wr(`DSWC_ADDR_CTRL, 32'h4, 4'hf);
      go_sleep();
      repeat (150) @(posedge mclk);
      wake(5'h02, n);
      go_sleep();
      wake(5'h00, n);
      chk(32'(n > 250 && n < 320), 32'h1, "wdt time");
      rd(`DSWC_ADDR_WAKE_LOW, 32'h10, "low");
      wr(`DSWC_ADDR_CTRL, 32'h0, 4'hf);
      go_sleep();
      repeat (300) @(posedge mclk);
      chk(32'(deep_sleep_active), 32'h1, "asleep");
      wake(5'h02, n);
      wr(`DSWC_ADDR_CTRL, 32'hc, 4'hf);
      go_sleep();
      repeat (300) @(posedge mclk);
      chk(32'(deep_sleep_active), 32'h1, "asleep");
      t1_on <= 1'b1;
      wake(5'h00, n);
      rd(`DSWC_ADDR_WAKE_LOW, 32'h10, "low");
      go_sleep();
      wake(5'h01, n);
      chk(32'(pins_hold), 32'h0, "pins");
      rd(`DSWC_ADDR_WAKE_LOW, 32'h04, "low");
      rd(`DSWC_ADDR_RETAIN0, 32'hcafe1200, "retain");
      stop_test();
   end
endmodule

// ### verification/dswc_wake_model.sv
// partner model: wake pins and watchdog clock ticks
`timescale 1ns/1ps
module dswc_wake_model (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // bench commands: 0 clear, 1 power-on, 2 alarm, 3 pin0, 4 ulp
   input wire logic [4:0] fire,
   input wire logic t1_on,
   // wake pins
   output logic master_clear_pin,
   output logic power_on_event,
   output logic calendar_alarm,
   output logic external_irq_pin0,
   output logic ultra_low_power_wake,
   // watchdog clock ticks
   output logic internal_rc_osc,
   output logic timer1_crystal_osc
);
   logic [1:0] div;
   // wake pins follow the commanded levels
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         {ultra_low_power_wake, external_irq_pin0, calendar_alarm, power_on_event,
            master_clear_pin} <= 5'h00;
      end else begin
         {ultra_low_power_wake, external_irq_pin0, calendar_alarm, power_on_event,
            master_clear_pin} <= fire;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div <= 2'h0;
         internal_rc_osc <= 1'b0;
         timer1_crystal_osc <= 1'b0;
      end else begin
         div <= div + 2'h1;
         internal_rc_osc <= (div == 2'h0);
         timer1_crystal_osc <= t1_on && (div == 2'h2);
      end
   end
endmodule
